/* File: pept_pkg.sv */
// Purpose: shared constants for the pulse-echo position timer channel
// Assumes: one core clock, APB register access with 32-bit data
// Notes: offsets are byte addresses of aligned words
package pept_pkg;
  localparam int unsigned CORE_CLK_HZ = 40000000;
  localparam int unsigned CORE_PERIOD_NS = 25;
  // lsb of the latched timer is one core clock period
  localparam int unsigned HF_PERIOD_PS = 8477;
  localparam int unsigned HF_PERIOD_NEW_PS = 1667;
  localparam int unsigned TIMER_W = 24;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned WORD_PAD = WORD_W - TIMER_W;
  localparam int unsigned CMD_W = 24;
  localparam int unsigned FMT_W = 4;
  localparam int unsigned DEC_W = 4;
  localparam int unsigned WID_W = 8;
  localparam int unsigned DIV_W = 8;
  localparam int unsigned FMT_PFM_BIT = 1;
  localparam logic [DEC_W-1:0] DEC_PULSE_ECHO = 4'hc;
  // register offsets
  localparam logic [7:0] OFS_FORMAT = 8'h00;
  localparam logic [7:0] OFS_DECODE = 8'h04;
  localparam logic [7:0] OFS_FREQ = 8'h08;
  localparam logic [7:0] OFS_WIDTH = 8'h0c;
  localparam logic [7:0] OFS_CLKDIV = 8'h10;
  localparam logic [7:0] OFS_ECHO = 8'h14;
  localparam logic [7:0] OFS_COUNT = 8'h18;
  // reset values
  localparam logic [FMT_W-1:0] RST_FORMAT = 4'h0;
  localparam logic [DEC_W-1:0] RST_DECODE = 4'h0;
  localparam logic [CMD_W-1:0] RST_FREQ = 24'h000000;
  localparam logic [WID_W-1:0] RST_WIDTH = 8'h0f;
  localparam logic [DIV_W-1:0] RST_CLKDIV = 8'h00;
endpackage

/* File: pept_pulse_if.sv */
// Purpose: carrier between the channel top and the excitation generator
// Assumes: single clock domain
// Notes: tick marks one pulse-modulation clock period
`timescale 1ns/1ps
interface pept_pulse_if;
  logic tick;
  logic enable;
  logic [pept_pkg::CMD_W-1:0] freq_cmd;
  logic [pept_pkg::WID_W-1:0] width;
  logic pulse;
  modport ctrl (output tick, output enable, output freq_cmd, output width, input pulse);
  modport gen (input tick, input enable, input freq_cmd, input width, output pulse);
endinterface

/* File: pept_pulse_gen.sv */
// Purpose: phase-accumulator excitation pulse generator
// Assumes: tick is a one-cycle strobe at the pulse-modulation rate
// Notes: a carry while a pulse is still running is dropped
`timescale 1ns/1ps
module pept_pulse_gen (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset, active high
  pept_pulse_if.gen pif // control and pulse
);
  logic [pept_pkg::CMD_W-1:0] acc_reg;
  logic [pept_pkg::WID_W-1:0] left_reg;
  logic pulse_reg;
  logic [pept_pkg::CMD_W:0] sum;

  // rate = cmd / 2^24 times the tick rate
  assign sum = {1'b0, acc_reg} + {1'b0, pif.freq_cmd};
  assign pif.pulse = pulse_reg;

  // accumulator advances once per tick
  always_ff @(posedge clk) begin
    if (rst || !pif.enable) begin
      acc_reg <= '0;
    end else if (pif.tick) begin
      acc_reg <= sum[pept_pkg::CMD_W-1:0];
    end
  end

  // pulse lasts width ticks; zero width still gives one tick
  always_ff @(posedge clk) begin
    if (rst || !pif.enable) begin
      pulse_reg <= 1'b0;
      left_reg <= '0;
    end else if (pif.tick) begin
      if (!pulse_reg && sum[pept_pkg::CMD_W]) begin
        pulse_reg <= 1'b1;
        left_reg <= pif.width;
      end else if (pulse_reg && left_reg <= 8'h01) begin
        pulse_reg <= 1'b0;
      end else if (pulse_reg) begin
        left_reg <= left_reg - 8'h01;
      end
    end
  end

  a_pulse_start: assert property (@(posedge clk) disable iff (rst)
    pif.enable && pif.tick && !pulse_reg && sum[pept_pkg::CMD_W] |=> pulse_reg)
    else $error("carry did not start a pulse");
  // while enabled, a running pulse may only end on a tick, so its length is counted in ticks
  a_pulse_hold: assert property (@(posedge clk) disable iff (rst)
    pif.enable && pulse_reg && !pif.tick |=> pulse_reg)
    else $error("pulse ended between ticks");
endmodule // pept_pulse_gen

/* File: pept_top.sv */
// Purpose: pulse-echo position timer channel with apb register access
// Assumes: ECHO_IN synchronous to CORE_CLK; timer counts CORE_CLK periods
// Notes: quadrature decode is not offered; echo mode owns the inputs
// Operation
// - pulse output when format bit 1 set
// - decode value twelve selects echo timing
// - timer clears on excitation falling edge
// - timer counts each clock until echo rise
// - echo rise latches timer into status
// - echo mode takes the encoder inputs
// - pulse counter still counts returned pulses
// - timer lsb equals one clock period
// - latch sits in upper 24 bits
// - rate is command over 2^24, not retained
// - pulse lasts width setting ticks, one tick for width zero, default fifteen
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module pept_top (
  input wire logic CORE_CLK, // core clock
  input wire logic RST, // synchronous reset, active high
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error, unmapped address
  input wire logic ECHO_IN, // return pulse from sensor
  output logic EXCITE_OUT // excitation pulse to sensor
);
  pept_pulse_if pif ();

  logic [pept_pkg::FMT_W-1:0] output_format_select_reg;
  logic [pept_pkg::DEC_W-1:0] feedback_decode_select_reg;
  logic [pept_pkg::CMD_W-1:0] freq_cmd_reg;
  logic [pept_pkg::WID_W-1:0] pulse_width_cycles_reg;
  logic [pept_pkg::DIV_W-1:0] clock_divider_setup_reg;
  logic [pept_pkg::DIV_W-1:0] div_cnt_reg;
  logic tick_reg;
  logic excite_reg;
  logic echo_d_reg;
  logic running_reg;
  logic [pept_pkg::TIMER_W-1:0] timer_reg;
  logic [pept_pkg::TIMER_W-1:0] echo_time_latch_reg;
  logic [31:0] pulse_count_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic pfm_on;
  logic echo_mode;
  logic excite_fall;
  logic echo_rise;
  logic apb_done;
  logic [31:0] rd_next;
  logic hit;

  // true when the address maps to a register
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == pept_pkg::OFS_FORMAT) || (a == pept_pkg::OFS_DECODE) || (a == pept_pkg::OFS_FREQ) ||
             (a == pept_pkg::OFS_WIDTH) || (a == pept_pkg::OFS_CLKDIV) || (a == pept_pkg::OFS_ECHO) ||
             (a == pept_pkg::OFS_COUNT);
  endfunction

  // mode decode
  assign pfm_on = output_format_select_reg[pept_pkg::FMT_PFM_BIT];
  assign echo_mode = (feedback_decode_select_reg == pept_pkg::DEC_PULSE_ECHO);
  assign excite_fall = excite_reg && !pif.pulse;
  assign echo_rise = ECHO_IN && !echo_d_reg;
  assign apb_done = PSEL && PENABLE && pready_reg;
  assign hit = mapped(PADDR);

  // generator hookup; disabled while the output is width-modulated
  assign pif.tick = tick_reg;
  assign pif.enable = pfm_on;
  assign pif.freq_cmd = freq_cmd_reg;
  assign pif.width = pulse_width_cycles_reg;

  pept_pulse_gen u_gen (
    .clk(CORE_CLK),
    .rst(RST),
    .pif(pif)
  );

  // pulse-modulation clock divider: tick every div+1 cycles
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      div_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (div_cnt_reg >= clock_divider_setup_reg) begin
      div_cnt_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
      tick_reg <= 1'b0;
    end
  end

  // output pin; width-modulated form is not built, pin idles low
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      excite_reg <= 1'b0;
    end else begin
      excite_reg <= pif.pulse && pfm_on;
    end
  end

  // echo edge history
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      echo_d_reg <= 1'b0;
    end else begin
      echo_d_reg <= ECHO_IN;
    end
  end

  // echo timer: clear on excitation fall, count, latch on echo rise
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      running_reg <= 1'b0;
      timer_reg <= '0;
      echo_time_latch_reg <= '0;
    end else if (!echo_mode) begin
      running_reg <= 1'b0;
    end else if (excite_fall) begin
      running_reg <= 1'b1;
      timer_reg <= '0;
    end else if (running_reg && echo_rise) begin
      running_reg <= 1'b0;
      echo_time_latch_reg <= timer_reg;
    end else if (running_reg) begin
      timer_reg <= timer_reg + 24'h000001;
    end
  end

  // returned pulses are still counted, position aside
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pulse_count_reg <= '0;
    end else if (echo_mode && echo_rise) begin
      pulse_count_reg <= pulse_count_reg + 32'h00000001;
    end
  end

  // register writes land on the completing access edge
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      output_format_select_reg <= pept_pkg::RST_FORMAT;
      feedback_decode_select_reg <= pept_pkg::RST_DECODE;
      freq_cmd_reg <= pept_pkg::RST_FREQ;
      pulse_width_cycles_reg <= pept_pkg::RST_WIDTH;
      clock_divider_setup_reg <= pept_pkg::RST_CLKDIV;
    end else if (apb_done && PWRITE) begin
      case (PADDR)
        pept_pkg::OFS_FORMAT: output_format_select_reg <= PWDATA[pept_pkg::FMT_W-1:0];
        pept_pkg::OFS_DECODE: feedback_decode_select_reg <= PWDATA[pept_pkg::DEC_W-1:0];
        pept_pkg::OFS_FREQ: freq_cmd_reg <= PWDATA[pept_pkg::CMD_W-1:0];
        pept_pkg::OFS_WIDTH: pulse_width_cycles_reg <= PWDATA[pept_pkg::WID_W-1:0];
        pept_pkg::OFS_CLKDIV: clock_divider_setup_reg <= PWDATA[pept_pkg::DIV_W-1:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped reads give zero
  always_comb begin
    rd_next = '0;
    case (PADDR)
      pept_pkg::OFS_FORMAT: rd_next = {28'h0000000, output_format_select_reg};
      pept_pkg::OFS_DECODE: rd_next = {28'h0000000, feedback_decode_select_reg};
      pept_pkg::OFS_FREQ: rd_next = {8'h00, freq_cmd_reg};
      pept_pkg::OFS_WIDTH: rd_next = {24'h000000, pulse_width_cycles_reg};
      pept_pkg::OFS_CLKDIV: rd_next = {24'h000000, clock_divider_setup_reg};
      pept_pkg::OFS_ECHO: rd_next = {echo_time_latch_reg, {pept_pkg::WORD_PAD{1'b0}}};
      pept_pkg::OFS_COUNT: rd_next = pulse_count_reg;
      default: rd_next = '0;
    endcase
  end

  // one wait state keeps ready and read data on flops
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else if (PSEL && PENABLE && !pready_reg) begin
      pready_reg <= 1'b1;
      pslverr_reg <= !hit;
      prdata_reg <= PWRITE ? 32'h00000000 : rd_next;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign EXCITE_OUT = excite_reg;

  a_timer_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
    echo_mode && excite_fall |=> timer_reg == 24'h000000 && running_reg)
    else $error("timer not cleared on excitation fall");
  a_timer_count: assert property (@(posedge CORE_CLK) disable iff (RST)
    echo_mode && running_reg && !echo_rise && !excite_fall |=> timer_reg == $past(timer_reg) + 24'h000001)
    else $error("timer did not advance by one");
  a_latch_capture: assert property (@(posedge CORE_CLK) disable iff (RST)
    echo_mode && running_reg && echo_rise && !excite_fall |=> echo_time_latch_reg == $past(timer_reg) && !running_reg)
    else $error("echo edge did not latch the timer");
  // read data is taken on the first access cycle, so compare against the latch as it stood then
  a_word_layout: assert property (@(posedge CORE_CLK) disable iff (RST)
    PSEL && PENABLE && !pready_reg && !PWRITE && PADDR == pept_pkg::OFS_ECHO
    |=> PRDATA[7:0] == 8'h00 && PRDATA[31:8] == $past(echo_time_latch_reg))
    else $error("echo word layout wrong");
  a_pfm_gate: assert property (@(posedge CORE_CLK) disable iff (RST)
    !pfm_on |=> !EXCITE_OUT)
    else $error("excitation while not in pulse format");
  a_mode_excl: assert property (@(posedge CORE_CLK) disable iff (RST)
    !echo_mode |=> !running_reg && $stable(echo_time_latch_reg))
    else $error("echo timing outside echo decode");
  a_count_echo: assert property (@(posedge CORE_CLK) disable iff (RST)
    echo_mode && echo_rise |=> pulse_count_reg == $past(pulse_count_reg) + 32'h00000001)
    else $error("returned pulse not counted");
  a_apb_ready: assert property (@(posedge CORE_CLK) disable iff (RST)
    PSEL && PENABLE && !pready_reg |=> PREADY ##1 !PREADY)
    else $error("apb ready not one cycle after access");
  c_echo_latch: cover property (@(posedge CORE_CLK) disable iff (RST) echo_mode && running_reg && echo_rise);
  c_excite_pulse: cover property (@(posedge CORE_CLK) disable iff (RST) $fell(EXCITE_OUT) && echo_mode);
  c_bad_addr: cover property (@(posedge CORE_CLK) disable iff (RST) PREADY && PSLVERR);
endmodule // pept_top

/* File: pept_sensor_model.sv */
// Purpose: behavioural sensor that answers the latest excitation with an echo
// Assumes: echo flight counted in core clock cycles after the excitation falls
// Notes: echo idles low between answers, like a terminated line receiver
`timescale 1ns/1ps
module pept_sensor_model (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset, active high
  input wire logic excite, // excitation pulse from the channel
  input wire logic [7:0] delay, // flight cycles after the fall, at least 2
  output logic echo // return pulse to the channel
);
  logic exc_d_reg;
  logic run_reg;
  logic [7:0] cnt_reg;
  logic [2:0] hold_reg;
  // a new fall restarts the flight, so only the latest excitation is answered
  always_ff @(posedge clk) begin
    if (rst) begin
      exc_d_reg <= 1'b0;
      run_reg <= 1'b0;
      cnt_reg <= 8'h00;
      hold_reg <= 3'h0;
      echo <= 1'b0;
    end else begin
      exc_d_reg <= excite;
      if (echo && hold_reg != 3'h0) begin
        hold_reg <= hold_reg - 3'h1;
      end else begin
        echo <= 1'b0;
      end
      if (exc_d_reg && !excite) begin
        run_reg <= 1'b1;
        cnt_reg <= 8'h01;
      end else if (run_reg) begin
        cnt_reg <= cnt_reg + 8'h01;
        if (cnt_reg + 8'h01 == delay) begin
          run_reg <= 1'b0;
          echo <= 1'b1;
          hold_reg <= 3'h4;
        end
      end
    end
  end
endmodule // pept_sensor_model

/* File: pulse_echo_position_timer_tb.sv */
// Purpose: self-checking bench for the pulse-echo position timer channel
// Assumes: apb master drives at rising edges; sensor model answers excitations
// Notes: random flight times come from a 16-bit lfsr seeded with 7077
`timescale 1ns/1ps
module pulse_echo_position_timer_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic echo;
  logic excite;
  logic [7:0] delay = 8'h02;
  logic [15:0] lfsr_reg = 16'h1ba5;
  logic echo_mode = 1'b0;
  logic echo_d = 1'b0;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int n_compared = 0;
  int n_echo = 0;
  logic [7:0] ofs[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  logic [31:0] rv[7] = '{32'(pept_pkg::RST_FORMAT), 32'(pept_pkg::RST_DECODE), 32'(pept_pkg::RST_FREQ),
    32'(pept_pkg::RST_WIDTH), 32'(pept_pkg::RST_CLKDIV), 32'h00000000, 32'h00000000};
  logic [7:0] cw[3] = '{8'h0f, 8'h03, 8'h01};
  logic [7:0] cd[3] = '{8'h00, 8'h01, 8'h02};
  logic [23:0] cf[3] = '{24'h010000, 24'h020000, 24'h008000};
  logic [3:0] cm[3] = '{4'h3, 4'h2, 4'h3};

  always #12.5 clk = ~clk;

  pept_top uut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ECHO_IN(echo), .EXCITE_OUT(excite));
  pept_sensor_model sensor (.clk(clk), .rst(rst), .excite(excite), .delay(delay), .echo(echo));

  // own count of echo rises while the channel is in echo mode
  always @(posedge clk) begin
    echo_d <= echo;
    if (echo_mode && echo === 1'b1 && echo_d === 1'b0) n_echo <= n_echo + 1;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask

  task automatic wait_excite(input logic lvl);
    int n;
    n = 0;
    while (excite !== lvl && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(excite), 32'(lvl));
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    int hi;
    int per;
    logic [31:0] r;
    logic [7:0] d;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b1, 8'h1c, 32'hffffffff);
    chk(32'(err), 32'h1);
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h0);
    r = {lfsr_reg, lfsr_next(lfsr_reg)};
    lfsr_reg = lfsr_next(lfsr_next(lfsr_reg));
    apb(1'b1, pept_pkg::OFS_FREQ, r);
    apb(1'b0, pept_pkg::OFS_FREQ, 32'h0);
    chk(rd, {8'h00, r[23:0]});
    apb(1'b1, pept_pkg::OFS_DECODE, 32'h0000000c);
    apb(1'b0, pept_pkg::OFS_DECODE, 32'h0);
    chk(rd, 32'h0000000c);
    echo_mode = 1'b1;
    $display("register test done");
    // formats without bit 1 must keep the pin quiet
    apb(1'b1, pept_pkg::OFS_FREQ, 32'h00010000);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, pept_pkg::OFS_FORMAT, 32'(m));
      hi = 0;
      repeat (600) @(posedge clk) if (excite !== 1'b0) hi++;
      chk(hi, 0);
    end
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, pept_pkg::OFS_WIDTH, 32'(cw[c]));
      apb(1'b1, pept_pkg::OFS_CLKDIV, 32'(cd[c]));
      apb(1'b1, pept_pkg::OFS_FREQ, 32'(cf[c]));
      apb(1'b1, pept_pkg::OFS_FORMAT, 32'(cm[c]));
      repeat (2) begin
        wait_excite(1'b0);
        wait_excite(1'b1);
      end
      hi = 0;
      per = 0;
      while (excite === 1'b1 && hi < 5000) begin
        @(posedge clk);
        hi++;
      end
      per = hi;
      while (excite !== 1'b1 && per < 5000) begin
        @(posedge clk);
        per++;
      end
      chk(hi, ((cw[c] < 2) ? 1 : cw[c]) * (cd[c] + 1));
      chk(per, ((1 << 24) / cf[c]) * (cd[c] + 1));
    end
    $display("excitation test done");
    // last config left at width 1, divider 2, period 1536 cycles
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 8'd2 : (i == 1) ? 8'd200 : 8'(2 + lfsr_reg % 150);
      lfsr_reg = lfsr_next(lfsr_reg);
      wait_excite(1'b1);
      delay <= d;
      wait_excite(1'b0);
      hi = 0;
      while (echo !== 1'b1 && hi < 400) begin
        @(posedge clk);
        hi++;
      end
      apb(1'b0, pept_pkg::OFS_ECHO, 32'h0);
      chk(rd, {16'h0000, d, 8'h00});
    end
    apb(1'b0, pept_pkg::OFS_COUNT, 32'h0);
    chk(rd, 32'(n_echo));
    $display("echo test done");
    // leaving echo decode stops the returned-pulse count
    wait_excite(1'b1);
    echo_mode = 1'b0;
    apb(1'b1, pept_pkg::OFS_DECODE, 32'h0);
    repeat (800) @(posedge clk);
    apb(1'b0, pept_pkg::OFS_COUNT, 32'h0);
    chk(rd, 32'(n_echo));
    $display("decode test done");
    end_of_test();
  end

  // watchdog well beyond the expected run of about 27000 cycles
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule // pulse_echo_position_timer_tb
